//--- hw/fle_pkg.sv
// Package for the flash LED fault and enable register bank.
// Assumes an upstream serial slave that presents byte-wide register accesses.
package fle_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] OFS_SECOND_TORCH  = 8'h0B;
    localparam logic [7:0] OFS_FAULT_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_FIRST_AT_LIM  = 8'h0D;
    localparam logic [7:0] OFS_SECOND_AT_LIM = 8'h0E;
    localparam logic [7:0] OFS_CHANNEL_EN    = 8'h0F;

    // ========================================================================
    // Field positions and widths
    localparam int TORCH_W       = 5;
    localparam int FLASH_W       = 6;
    localparam int BIT_OVERVOLT  = 7;
    localparam int BIT_SHORT     = 6;
    localparam int BIT_OVERTEMP  = 5;
    localparam int BIT_TIMEOUT   = 4;
    localparam int BIT_TXRED     = 3;
    localparam int BIT_LOWSUP    = 2;
    localparam int BIT_INDLIM    = 1;
    localparam int BIT_DCLIM     = 0;
    localparam int BIT_FIRST_ON  = 0;
    localparam int BIT_SECOND_ON = 1;

    // ========================================================================
    // Reset values
    localparam logic [7:0] RST_SECOND_TORCH = 8'h04;
    localparam logic [7:0] RST_CHANNEL_EN   = 8'h00;
    localparam logic [7:0] RST_FAULT        = 8'h00;
    localparam logic [7:0] RST_AT_LIM       = 8'h00;

    // Torch current step in microamps and saturating top code
    localparam int          TORCH_STEP_UA = 18700;
    localparam logic [4:0]  TORCH_SAT     = 5'h18;

    // Analog condition inputs, all asynchronous to clk
    typedef struct packed {
        logic overvoltage;
        logic short_circuit;
        logic overtemperature;
        logic flash_timeout;
        logic tx_reduction;
        logic low_supply;
        logic inductor_peak;
        logic battery_dc;
    } fle_cond_t;

    // Byte-wide register access from the serial slave
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fle_req_t;

endpackage : fle_pkg

//--- hw/fle_sync.sv
// Two-flop synchroniser, one bit per lane.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/1ps
module fle_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : fle_sync

//--- hw/fle_regs.sv
// Upper control/status registers of a dual LED flash driver.
// Assumes a serial slave delivers one-cycle byte read/write strobes on clk,
// and the analog side delivers raw condition levels and flash-start pulses.
`timescale 1ns/1ps

module fle_regs (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire fle_pkg::fle_req_t        req,
    output logic      [7:0]               rdata,
    output logic                          rvalid,
    input  wire fle_pkg::fle_cond_t       cond_raw,
    input  wire logic                     flash_start,
    input  wire logic                     low_supply_detect_en,
    input  wire logic                     dc_limit_en,
    input  wire logic [5:0]               first_flash_code,
    input  wire logic [5:0]               second_flash_code,
    output logic      [4:0]               second_torch_level,
    output logic                          first_channel_on,
    output logic                          second_channel_on
);

    // ========================================================================
    // Condition synchronisers
    fle_pkg::fle_cond_t cond_s;
    logic [7:0]         cond_q;

    fle_sync #(.W(8)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (cond_raw),
        .q   (cond_q)
    );
    assign cond_s = fle_pkg::fle_cond_t'(cond_q);

    // ========================================================================
    // Decode
    function automatic logic hit(input fle_pkg::fle_req_t r,
                                 input logic [7:0] ofs);
        hit = (r.addr == ofs);
    endfunction : hit

    wire wr_torch = req.wr && hit(req, fle_pkg::OFS_SECOND_TORCH);
    wire wr_en    = req.wr && hit(req, fle_pkg::OFS_CHANNEL_EN);

    // ========================================================================
    // Second torch register
    logic [7:0] torch_r;
    logic [7:0] torch_nxt;

    assign torch_nxt = wr_torch ? req.wdata : torch_r;

    always_ff @(posedge clk) begin
        if (rst) torch_r <= fle_pkg::RST_SECOND_TORCH;
        else     torch_r <= torch_nxt;
    end

    // Codes past the saturating code all drive the same current.
    // Taken from the next value so the level moves one cycle after the
    // write, in step with the channel enables.
    wire [4:0] torch_code = torch_nxt[fle_pkg::TORCH_W-1:0];
    wire [4:0] torch_lvl_nxt =
        (torch_code > fle_pkg::TORCH_SAT) ? fle_pkg::TORCH_SAT
                                          : torch_code;

    // ========================================================================
    // Channel enable with interlock
    logic [7:0] en_r;
    logic [7:0] en_nxt;

    wire cur_first  = en_r[fle_pkg::BIT_FIRST_ON];
    wire cur_second = en_r[fle_pkg::BIT_SECOND_ON];
    wire req_first  = req.wdata[fle_pkg::BIT_FIRST_ON];
    wire req_second = req.wdata[fle_pkg::BIT_SECOND_ON];
    // Interlock judged against state before the write, so a joint set
    // from both-off passes while a late add-on is refused.
    wire new_first  = req_first & ~(cur_second & ~cur_first);
    wire new_second = req_second & ~(cur_first & ~cur_second);

    assign en_nxt = wr_en ? {req.wdata[7:2], new_second, new_first}
                          : en_r;

    always_ff @(posedge clk) begin
        if (rst) en_r <= fle_pkg::RST_CHANNEL_EN;
        else     en_r <= en_nxt;
    end

    // ========================================================================
    // Fault flags, follow live conditions except the reduction flag, sticky per flash
    logic [7:0] fault_r;
    logic [7:0] fault_nxt;
    logic       tx_seen_r;

    // Reduction flag is sticky within a flash, cleared on the next start;
    // a reduction in the start cycle itself still counts.
    wire tx_seen_nxt = cond_s.tx_reduction |
                       (tx_seen_r & ~flash_start);

    always_comb begin
        fault_nxt = fle_pkg::RST_FAULT;
        fault_nxt[fle_pkg::BIT_OVERVOLT] = cond_s.overvoltage;
        fault_nxt[fle_pkg::BIT_SHORT]    = cond_s.short_circuit;
        fault_nxt[fle_pkg::BIT_OVERTEMP] = cond_s.overtemperature;
        fault_nxt[fle_pkg::BIT_TIMEOUT]  = cond_s.flash_timeout;
        fault_nxt[fle_pkg::BIT_TXRED]    = tx_seen_nxt;
        fault_nxt[fle_pkg::BIT_LOWSUP]   =
            cond_s.low_supply & low_supply_detect_en;
        fault_nxt[fle_pkg::BIT_INDLIM]   = cond_s.inductor_peak;
        fault_nxt[fle_pkg::BIT_DCLIM]    =
            cond_s.battery_dc & dc_limit_en;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fault_r   <= fle_pkg::RST_FAULT;
            tx_seen_r <= 1'b0;
        end else begin
            fault_r   <= fault_nxt;  // no write path
            tx_seen_r <= tx_seen_nxt;
        end
    end

    // ========================================================================
    // Current capture on rising edge of dc limit
    logic [7:0] first_lim_r;
    logic [7:0] second_lim_r;

    wire dc_rise = fault_nxt[fle_pkg::BIT_DCLIM] &
                   ~fault_r[fle_pkg::BIT_DCLIM];

    always_ff @(posedge clk) begin
        if (rst) begin
            first_lim_r  <= fle_pkg::RST_AT_LIM;
            second_lim_r <= fle_pkg::RST_AT_LIM;
        end else if (dc_rise) begin
            first_lim_r  <= {2'b00, first_flash_code};
            second_lim_r <= {2'b00, second_flash_code};
        end
    end

    // ========================================================================
    // Read mux; unmapped offsets read zero
    logic [7:0] rd_mux;

    always_comb begin
        unique case (req.addr)
            fle_pkg::OFS_SECOND_TORCH:  rd_mux = torch_r;
            fle_pkg::OFS_FAULT_STATUS:  rd_mux = fault_r;
            fle_pkg::OFS_FIRST_AT_LIM:  rd_mux = first_lim_r;
            fle_pkg::OFS_SECOND_AT_LIM: rd_mux = second_lim_r;
            fle_pkg::OFS_CHANNEL_EN:    rd_mux = en_r;
            default:                    rd_mux = 8'h00;
        endcase
    end

    // ========================================================================
    // Output flops
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata              <= 8'h00;
            rvalid             <= 1'b0;
            second_torch_level <=
                fle_pkg::RST_SECOND_TORCH[fle_pkg::TORCH_W-1:0];
            first_channel_on   <= 1'b0;
            second_channel_on  <= 1'b0;
        end else begin
            rvalid             <= req.rd;
            rdata              <= req.rd ? rd_mux : rdata;
            second_torch_level <= torch_lvl_nxt;
            first_channel_on   <= en_nxt[fle_pkg::BIT_FIRST_ON];
            second_channel_on  <= en_nxt[fle_pkg::BIT_SECOND_ON];
        end
    end

endmodule : fle_regs

//--- tb/fle_regs_monitor.sv
// Checker for the flash LED register bank, top ports only.
// Assumes one clk domain, synchronous reset rst.
`timescale 1ns/1ps
module fle_regs_monitor (
    input wire logic              clk,
    input wire logic              rst,
    input wire fle_pkg::fle_req_t req,
    input wire logic [7:0]        rdata,
    input wire logic              rvalid,
    input wire logic [4:0]        second_torch_level,
    input wire logic              first_channel_on,
    input wire logic              second_channel_on
);
    // ========================================
    // Decode
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire en_wr = req.wr && req.addr == fle_pkg::OFS_CHANNEL_EN;
    wire tq_wr = req.wr && req.addr == fle_pkg::OFS_SECOND_TORCH;
    wire [4:0] wsat = req.wdata[4:0] > fle_pkg::TORCH_SAT ?
                      fle_pkg::TORCH_SAT : req.wdata[4:0];
    sequence s_both_off_wr;
        !first_channel_on && !second_channel_on && en_wr
            && req.wdata[1:0] == 2'h3;
    endsequence
    // ========================================
    // Properties
    AST_READ_ANSWER: assert property (req.rd |=> rvalid)
        else $error("no rvalid after read");
    AST_NO_ANSWER: assert property (!req.rd |=> !rvalid)
        else $error("rvalid without read");
    AST_RDATA_HOLD: assert property (!req.rd |=> $stable(rdata))
        else $error("rdata moved without read");
    AST_BOTH_ON: assert property (s_both_off_wr |=>
        first_channel_on && second_channel_on)
        else $error("joint enable refused");
    AST_SECOND_REFUSED: assert property (en_wr && first_channel_on
        && !second_channel_on |=> !second_channel_on)
        else $error("second enabled over first");
    AST_FIRST_REFUSED: assert property (en_wr && second_channel_on
        && !first_channel_on |=> !first_channel_on)
        else $error("first enabled over second");
    AST_EN_HOLD: assert property (!en_wr |=>
        $stable({first_channel_on, second_channel_on}))
        else $error("enable moved without write");
    AST_TORCH_SAT: assert property (tq_wr |=>
        second_torch_level == $past(wsat)) else $error("torch level wrong");
    AST_TORCH_HOLD: assert property (!tq_wr |=>
        $stable(second_torch_level)) else $error("torch level moved");
endmodule : fle_regs_monitor

bind fle_regs fle_regs_monitor u_mon (.clk, .rst, .req, .rdata, .rvalid,
    .second_torch_level, .first_channel_on, .second_channel_on);

//--- tb/fle_host.sv
// Host model: byte register accesses as the serial slave hands them on.
// Assumes the bench calls its tasks only after reset release.
`timescale 1ns/1ps
module fle_host (
    input  wire logic              clk,
    output fle_pkg::fle_req_t      req,
    input  wire logic [7:0]        rdata,
    input  wire logic              rvalid
);
    initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
    // Released address and data go inverted, never left at the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, 8'hFF};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rvalid !== 1'b1 && n < 4);
        d = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask : rd
endmodule : fle_host

//--- tb/flash_led_fault_enable_regs_tb.sv
// Self-checking bench for the flash LED register bank.
// Assumes the monitor is bound to the design and fle_host drives requests.
`timescale 1ns/1ps
module flash_led_fault_enable_regs_tb;
    logic clk, rst, flash_start, low_en, dc_en, rvalid, on1, on2;
    logic [7:0] rdata, v;
    logic [5:0] code1, code2;
    logic [4:0] level;
    fle_pkg::fle_req_t  req;
    fle_pkg::fle_cond_t cond_raw;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    fle_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    fle_regs dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .cond_raw(cond_raw), .flash_start(flash_start),
        .low_supply_detect_en(low_en), .dc_limit_en(dc_en),
        .first_flash_code(code1), .second_flash_code(code2),
        .second_torch_level(level), .first_channel_on(on1),
        .second_channel_on(on2));
    // ========================================
    // Checks
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(logic [7:0] a, logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rchk
    // ========================================
    // Scenarios
    logic [4:0] tq [4] = '{5'h00, 5'h08, 5'h18, 5'h1F};
    task automatic t_reset;
        rchk(8'h0B, 8'h04);
        rchk(8'h0C, 8'h00);
        rchk(8'h0D, 8'h00);
        rchk(8'h0E, 8'h00);
        rchk(8'h0F, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_torch;
        logic [4:0] c;
        foreach (tq[i]) begin
            c = tq[i];
            host.wr(8'h0B, {3'h5, c});
            rchk(8'h0B, {3'h5, c});
            chk("level", {3'h0, c > fle_pkg::TORCH_SAT ?
                fle_pkg::TORCH_SAT : c}, {3'h0, level});
        end
        $display("t_torch done");
    endtask : t_torch
    task automatic t_fault;
        for (int i = 7; i >= 0; i--) begin
            cond_raw <= 8'(1 << i);
            repeat (4) @(posedge clk);
            rchk(8'h0C, 8'(1 << i) | (i < 3 ? 8'h08 : 8'h00));
        end
        host.wr(8'h0C, 8'hFF);
        rchk(8'h0C, 8'h09);
        host.wr(8'h0D, 8'hFF);
        // Live codes move after the fault; captured values must not follow
        {code1, code2} <= {6'h3F, 6'h00};
        rchk(8'h0D, 8'h2A);
        rchk(8'h0E, 8'h15);
        {low_en, dc_en} <= 2'h0;
        cond_raw <= 8'h05;
        repeat (4) @(posedge clk);
        rchk(8'h0C, 8'h08);
        flash_start <= 1'b1;
        @(posedge clk);
        flash_start <= 1'b0;
        rchk(8'h0C, 8'h00);
        $display("t_fault done");
    endtask : t_fault
    task automatic t_enable;
        host.wr(8'h0F, 8'h01);
        host.wr(8'h0F, 8'h03);
        rchk(8'h0F, 8'h01);
        host.wr(8'h0F, 8'h00);
        host.wr(8'h0F, 8'h02);
        host.wr(8'h0F, 8'h03);
        rchk(8'h0F, 8'h02);
        host.wr(8'h0F, 8'h00);
        host.wr(8'h0F, 8'hFF);
        rchk(8'h0F, 8'hFF);
        chk("outputs", 8'h03, {6'h0, on2, on1});
        rchk(8'h20, 8'h00);
        $display("t_enable done");
    endtask : t_enable
    // ========================================
    // Run control
    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        {rst, flash_start, low_en, dc_en} = 4'hF - 4'h4;
        {code1, code2} = {6'h2A, 6'h15};
        cond_raw = 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_torch();
        t_fault();
        t_enable();
        print_verdict();
    end
endmodule : flash_led_fault_enable_regs_tb
